// [shared/memory_address_decode_cfg.svh]
// constants for the memory subsystem and data address decoder
`ifndef MEMORY_ADDRESS_DECODE_CFG_SVH
`define MEMORY_ADDRESS_DECODE_CFG_SVH

// word and half word widths
`define MAD_WORD_W           18
`define MAD_HALF_W           9
`define MAD_HALF_ZERO        9'h000
`define MAD_WORD_ZERO        18'h00000

// main memory geometry: row bits inside a block, block select bits above them
`define MAD_ROW_BITS         11
`define MAD_BLOCK_BITS       7
`define MAD_NUM_BLOCKS       8

// data address layout: bit 0 picks the half word, bits 17..1 the word
`define MAD_ALIGN_BIT        0
`define MAD_UPPER_MEMORY_SELECT_BIT 7

// region compare uses the upper 8 bits; the low 10 bits address inside
`define MAD_SEL_LSB          10
`define MAD_LOCAL_BITS       10
`define MAD_REG_BITS         3

// default base addresses of the peripheral window and the dma buffer
`define MAD_IO_BASE_ADDR     18'h3fc00
`define MAD_DMA_BASE_ADDR    18'h19000

// store lane codes: bit 1 upper half, bit 0 lower half
`define MAD_LANES_NONE       2'h0
`define MAD_LANES_BOTH       2'h3
`define MAD_LANES_UPPER      2'h2
`define MAD_LANES_LOWER      2'h1

`endif

// [shared/memory_address_decode_pkg.sv]
// types shared by the memory subsystem and its users
package memory_address_decode_pkg;

  // one data access from the processor core
  typedef struct packed {
    logic [17:0] addr;             // half word address, bit 0 = align
    logic        load_half_word;
    logic        load_full_word;
    logic        store_half_word;
    logic        store_full_word;
    logic [17:0] wdata;            // half word stores use bits 8..0
  } data_req_type;

  // decoded access toward the memory mapped peripheral registers
  typedef struct packed {
    logic        sel;
    logic [9:0]  addr;
    logic        write;
    logic [17:0] wdata;
  } periph_bus_type;

  // peripheral side port of the dma buffer
  typedef struct packed {
    logic [9:0]  row;
    logic [1:0]  lanes;
    logic [17:0] wdata;
  } dma_port_type;

  // target of a data access
  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_MAIN,
    REGION_IO,
    REGION_DMA
  } region_type;

endpackage : memory_address_decode_pkg

// [design/dual_port_block.sv]
// dual ported memory block of 18 bit words built from two 9 bit halves
`include "memory_address_decode_cfg.svh"

module dual_port_block #(
  parameter int ROW_BITS = `MAD_ROW_BITS
) (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // port a
  input  wire logic [ROW_BITS-1:0]    a_row_i,
  input  wire logic                   a_rd_i,
  input  wire logic [1:0]             a_lanes_i,
  input  wire logic [`MAD_WORD_W-1:0] a_wdata_i,
  output logic      [`MAD_WORD_W-1:0] a_rdata_o,
  // port b
  input  wire logic [ROW_BITS-1:0]    b_row_i,
  input  wire logic                   b_rd_i,
  input  wire logic [1:0]             b_lanes_i,
  input  wire logic [`MAD_WORD_W-1:0] b_wdata_i,
  output logic      [`MAD_WORD_W-1:0] b_rdata_o
);

  localparam int ROWS = 2 ** ROW_BITS;

  logic [`MAD_HALF_W-1:0] upper_mem [ROWS];
  logic [`MAD_HALF_W-1:0] lower_mem [ROWS];
  logic [`MAD_WORD_W-1:0] a_rdata_reg;
  logic [`MAD_WORD_W-1:0] b_rdata_reg;

  // upper half array; both ports may write, port b wins when both write one row
  always_ff @(posedge clk_sys_i)
  begin
    if (a_lanes_i[1])
      upper_mem[a_row_i] <= a_wdata_i[17:9];
    if (b_lanes_i[1])
      upper_mem[b_row_i] <= b_wdata_i[17:9];
  end

  // lower half array, written apart so a half store keeps the other half
  always_ff @(posedge clk_sys_i)
  begin
    if (a_lanes_i[0])
      lower_mem[a_row_i] <= a_wdata_i[8:0];
    if (b_lanes_i[0])
      lower_mem[b_row_i] <= b_wdata_i[8:0];
  end

  // synchronous reads; an unselected port shows zero for the or bus
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_rdata_reg <= `MAD_WORD_ZERO;
      b_rdata_reg <= `MAD_WORD_ZERO;
    end
    else
    begin
      a_rdata_reg <= a_rd_i ? {upper_mem[a_row_i], lower_mem[a_row_i]} : `MAD_WORD_ZERO;
      b_rdata_reg <= b_rd_i ? {upper_mem[b_row_i], lower_mem[b_row_i]} : `MAD_WORD_ZERO;
    end
  end

  assign a_rdata_o = a_rdata_reg;
  assign b_rdata_o = b_rdata_reg;

endmodule : dual_port_block

// [design/memory_address_decode.sv]
// main memory, dma buffer and data address decoder of the soft processor
// Functional notes
// - main memory: blocks of 2k x 18, two halves
// - blocks dual ported: fetch port, data port
// - big endian: upper half at lower address
// - low 11 bits row, upper 7 bits block
// - instruction port addressed by program counter
// - data bit 0 picks half, 17 bits word
// - status bit 7 is top word address bit
// - peripheral space on upper 8 bit match
// - low 10 bits: module base, register index
// - peripheral writes full word, align ignored
// - dma buffer dual ported, second port peripheral
// - dma hit on upper 8 bits, 10 bit row
// - dma writes per half lane strobes
// - no instruction fetch from dma buffer
// - read data merged by or, idle zero
`include "memory_address_decode_cfg.svh"

module memory_address_decode #(
  parameter int          NUM_BLOCKS = `MAD_NUM_BLOCKS,
  parameter int          REG_BITS   = `MAD_REG_BITS,
  parameter logic [17:0] IO_BASE    = `MAD_IO_BASE_ADDR,
  parameter logic [17:0] DMA_BASE   = `MAD_DMA_BASE_ADDR
) (
  // clock and reset
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  rst_i,
  // instruction port
  input  wire logic [`MAD_WORD_W-1:0]                pc_i,
  output logic      [`MAD_WORD_W-1:0]                instr_o,
  // data port of the core
  input  wire memory_address_decode_pkg::data_req_type data_req_i,
  input  wire logic [`MAD_WORD_W-1:0]                status_i,
  output logic      [`MAD_WORD_W-1:0]                data_rdata_o,
  // memory mapped peripheral registers
  output memory_address_decode_pkg::periph_bus_type  periph_o,
  output logic      [`MAD_LOCAL_BITS-REG_BITS-1:0]   periph_module_o,
  output logic      [REG_BITS-1:0]                   periph_reg_o,
  input  wire logic [`MAD_WORD_W-1:0]                periph_rdata_i,
  // peripheral side of the dma buffer
  input  wire memory_address_decode_pkg::dma_port_type dma_port_i,
  input  wire logic                                  dma_rd_i,
  output logic      [`MAD_WORD_W-1:0]                dma_rdata_o
);

  localparam int ROW_BITS   = `MAD_ROW_BITS;
  localparam int BLOCK_BITS = `MAD_BLOCK_BITS;
  localparam int LOCAL_BITS = `MAD_LOCAL_BITS;

  // upper 8 bits of two word addresses agree
  function automatic logic base_match(input logic [17:0] addr, input logic [17:0] base);
    base_match = (addr[17:`MAD_SEL_LSB] == base[17:`MAD_SEL_LSB]);
  endfunction : base_match

  // half lanes of a store; align 0 is the upper half
  function automatic logic [1:0] store_lanes(input logic full, input logic half,
                                             input logic align);
    if (full)
      store_lanes = `MAD_LANES_BOTH;
    else if (half)
      store_lanes = align ? `MAD_LANES_LOWER : `MAD_LANES_UPPER;
    else
      store_lanes = `MAD_LANES_NONE;
  endfunction : store_lanes

  // write data of a store; a half word is copied to both halves
  function automatic logic [17:0] store_data(input logic half, input logic [17:0] wdata);
    store_data = half ? {wdata[8:0], wdata[8:0]} : wdata;
  endfunction : store_data

  // word address with the status bit on top of the 17 data address bits
  logic                            align;
  logic [`MAD_WORD_W-1:0]          word_addr;
  logic                            is_load;
  logic                            is_store;
  logic                            half_store;
  logic [1:0]                      lanes;
  logic [`MAD_WORD_W-1:0]          wdata_lanes;

  assign align       = data_req_i.addr[`MAD_ALIGN_BIT];
  assign word_addr   = {status_i[`MAD_UPPER_MEMORY_SELECT_BIT], data_req_i.addr[17:1]};
  assign is_load     = data_req_i.load_half_word | data_req_i.load_full_word;
  assign is_store    = data_req_i.store_half_word | data_req_i.store_full_word;
  assign half_store  = data_req_i.store_half_word & ~data_req_i.store_full_word;
  assign lanes       = store_lanes(data_req_i.store_full_word, data_req_i.store_half_word,
                                   align);
  assign wdata_lanes = store_data(half_store, data_req_i.wdata);

  // region decode; peripheral window first, then dma, then main memory
  logic                            io_hit;
  logic                            dma_hit;
  logic [BLOCK_BITS-1:0]           data_block;
  logic                            main_hit;
  memory_address_decode_pkg::region_type region;

  assign io_hit     = base_match(word_addr, IO_BASE);
  assign dma_hit    = base_match(word_addr, DMA_BASE) & ~io_hit;
  assign data_block = word_addr[17:ROW_BITS];
  assign main_hit   = ~io_hit & ~dma_hit & (32'(data_block) < NUM_BLOCKS);
  assign region     = io_hit   ? memory_address_decode_pkg::REGION_IO   :
                      dma_hit  ? memory_address_decode_pkg::REGION_DMA  :
                      main_hit ? memory_address_decode_pkg::REGION_MAIN :
                                 memory_address_decode_pkg::REGION_NONE;

  // peripheral register access; any store writes the whole word
  logic                            io_sel;

  assign io_sel          = (region == memory_address_decode_pkg::REGION_IO) & (is_load | is_store);
  assign periph_o.sel    = io_sel;
  assign periph_o.addr   = word_addr[LOCAL_BITS-1:0];
  assign periph_o.write  = io_sel & is_store;
  assign periph_o.wdata  = data_req_i.wdata;
  assign periph_module_o = word_addr[LOCAL_BITS-1:REG_BITS];
  assign periph_reg_o    = word_addr[REG_BITS-1:0];

  // main memory blocks; port a data, port b instruction fetch only
  logic [`MAD_WORD_W-1:0]          blk_data_rdata [NUM_BLOCKS];
  logic [`MAD_WORD_W-1:0]          blk_instr_rdata [NUM_BLOCKS];
  logic [BLOCK_BITS-1:0]           pc_block;

  assign pc_block = pc_i[17:ROW_BITS];

  for (genvar blk = 0; blk < NUM_BLOCKS; blk++)
  begin : g_block
    logic data_sel;
    logic instr_sel;

    // block select from the upper 7 address bits
    assign data_sel  = main_hit & (data_block == BLOCK_BITS'(blk));
    assign instr_sel = (pc_block == BLOCK_BITS'(blk));

    dual_port_block #(
      .ROW_BITS (ROW_BITS)
    ) u_block (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .a_row_i   (word_addr[ROW_BITS-1:0]),
      .a_rd_i    (data_sel & is_load),
      .a_lanes_i (data_sel ? lanes : `MAD_LANES_NONE),
      .a_wdata_i (wdata_lanes),
      .a_rdata_o (blk_data_rdata[blk]),
      .b_row_i   (pc_i[ROW_BITS-1:0]),
      .b_rd_i    (instr_sel),
      .b_lanes_i (`MAD_LANES_NONE),
      .b_wdata_i (`MAD_WORD_ZERO),
      .b_rdata_o (blk_instr_rdata[blk])
    );
  end

  // dma buffer; port a on the data bus, port b owned by the peripheral
  logic                            dma_sel;
  logic [`MAD_WORD_W-1:0]          dma_cpu_rdata;

  assign dma_sel = (region == memory_address_decode_pkg::REGION_DMA);

  dual_port_block #(
    .ROW_BITS (LOCAL_BITS)
  ) u_dma_buffer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .a_row_i   (word_addr[LOCAL_BITS-1:0]),
    .a_rd_i    (dma_sel & is_load),
    .a_lanes_i (dma_sel ? lanes : `MAD_LANES_NONE),
    .a_wdata_i (wdata_lanes),
    .a_rdata_o (dma_cpu_rdata),
    .b_row_i   (dma_port_i.row),
    .b_rd_i    (dma_rd_i),
    .b_lanes_i (dma_port_i.lanes),
    .b_wdata_i (dma_port_i.wdata),
    .b_rdata_o (dma_rdata_o)
  );

  // wide or of all read sources; idle sources hold zero, so no tri-state
  logic [`MAD_WORD_W-1:0]          data_or;
  logic [`MAD_WORD_W-1:0]          instr_or;

  always_comb
  begin
    data_or  = dma_cpu_rdata | periph_rdata_i;
    instr_or = `MAD_WORD_ZERO;
    for (int i = 0; i < NUM_BLOCKS; i++)
    begin
      data_or  = data_or | blk_data_rdata[i];
      instr_or = instr_or | blk_instr_rdata[i];
    end
  end

  // the dma buffer never feeds the fetch path
  assign instr_o = instr_or;

  // load shape is remembered for the cycle in which read data returns
  logic                            align_reg;
  logic                            half_load_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      align_reg     <= 1'b0;
      half_load_reg <= 1'b0;
    end
    else
    begin
      align_reg     <= align;
      half_load_reg <= data_req_i.load_half_word & ~data_req_i.load_full_word;
    end
  end

  // half word loads zero extend; align 0 returns the upper half
  logic [`MAD_HALF_W-1:0]          half_sel;

  assign half_sel     = align_reg ? data_or[8:0] : data_or[17:9];
  assign data_rdata_o = half_load_reg ? {`MAD_HALF_ZERO, half_sel} : data_or;

endmodule : memory_address_decode

// [verification/memory_address_decode_chk.sv]
// concurrent checks on the data decoder, fetch port and dma port
`include "memory_address_decode_cfg.svh"

module memory_address_decode_chk #(
  parameter int          NUM_BLOCKS = 8,
  parameter int          REG_BITS   = 3,
  parameter logic [17:0] IO_BASE    = 18'h3fc00
) (
  // clock and reset
  input wire logic                                    clk_sys_i,
  input wire logic                                    rst_i,
  // core side
  input wire logic [17:0]                             pc_i,
  input wire logic [17:0]                             instr_o,
  input wire memory_address_decode_pkg::data_req_type data_req_i,
  input wire logic [17:0]                             status_i,
  input wire logic [17:0]                             data_rdata_o,
  // peripheral side
  input wire memory_address_decode_pkg::periph_bus_type periph_o,
  input wire logic [`MAD_LOCAL_BITS-REG_BITS-1:0]     periph_module_o,
  input wire logic [REG_BITS-1:0]                     periph_reg_o,
  input wire logic [17:0]                             periph_rdata_i,
  input wire logic                                    dma_rd_i,
  input wire logic [17:0]                             dma_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] word_addr;
  logic        ld_any;
  logic        st_any;

  // word address with the status bit on top
  assign word_addr = {status_i[7], data_req_i.addr[17:1]};
  assign ld_any    = data_req_i.load_full_word | data_req_i.load_half_word;
  assign st_any    = data_req_i.store_full_word | data_req_i.store_half_word;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // select and write qualifiers are same-cycle decodes
  a_io_sel_match: assert property (
    periph_o.sel == ((ld_any | st_any) && word_addr[17:10] == IO_BASE[17:10]))
    else $error("io select wrong");
  a_io_write_full: assert property (
    periph_o.write == (periph_o.sel && st_any)) else $error("io write wrong");
  a_io_addr_split: assert property (
    periph_o.sel |-> periph_o.addr == word_addr[9:0]
      && {periph_module_o, periph_reg_o} == word_addr[9:0])
    else $error("io address split wrong");
  // read data appears one clock after the request
  a_io_read_pass: assert property (
    periph_o.sel && data_req_i.load_full_word && !st_any |=> data_rdata_o == periph_rdata_i)
    else $error("io read not passed");
  a_half_zero_ext: assert property (
    data_req_i.load_half_word && !data_req_i.load_full_word |=> data_rdata_o[17:9] == 9'h000)
    else $error("half load not zero extended");
  a_idle_or_zero: assert property (
    !ld_any |=> data_rdata_o == periph_rdata_i) else $error("memory not zero when idle");
  a_dma_idle_zero: assert property (
    !dma_rd_i |=> dma_rdata_o == 18'h00000) else $error("dma read not zero when idle");
  a_fetch_range: assert property (
    pc_i[17:11] >= NUM_BLOCKS |=> instr_o == 18'h00000) else $error("fetch out of range");

  c_io_load: cover property (periph_o.sel && ld_any);
  c_dma_read: cover property (dma_rd_i);
  c_half_store: cover property (data_req_i.store_half_word);
endmodule : memory_address_decode_chk

bind memory_address_decode memory_address_decode_chk #(
  .NUM_BLOCKS(NUM_BLOCKS), .REG_BITS(REG_BITS), .IO_BASE(IO_BASE)
) u_chk (
  .clk_sys_i, .rst_i, .pc_i, .instr_o, .data_req_i, .status_i, .data_rdata_o,
  .periph_o, .periph_module_o, .periph_reg_o, .periph_rdata_i, .dma_rd_i, .dma_rdata_o
);

// [verification/periph_regs_model.sv]
// peripheral register model answering the decoded register bus
module periph_regs_model (
  // clock and reset
  input  wire logic                                      clk_sys_i,
  input  wire logic                                      rst_i,
  // decoded register bus
  input  wire memory_address_decode_pkg::periph_bus_type periph_i,
  output logic      [17:0]                               rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] file_reg [1024];

  // synchronous read, zero when idle so the or bus stays clean
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 18'h00000;
    else
    begin
      if (periph_i.sel && periph_i.write)
        file_reg[periph_i.addr] <= periph_i.wdata;
      // idle read output is zero so the or bus stays clean
      rdata_o <= (periph_i.sel && !periph_i.write) ? file_reg[periph_i.addr] : 18'h00000;
    end
  end
endmodule : periph_regs_model

// [verification/tb.sv]
// self-checking bench for the memory subsystem and data address decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          NB  = 8;
  localparam logic [17:0] IOB = 18'h3fc00;
  localparam logic [17:0] DMB = 18'h19000;
  logic        clk_sys_i, rst_i, dma_rd_i;
  logic [17:0] pc_i, instr_o, status_i, data_rdata_o, periph_rdata_i, dma_rdata_o;
  logic [6:0]  periph_module_o;
  logic [2:0]  periph_reg_o;
  logic [17:0] mem [int];
  logic [17:0] alist [4] = '{18'h00000, 18'h007ff, 18'h00800, 18'h03fff};
  int          err_count, tests_run;
  memory_address_decode_pkg::data_req_type   data_req_i;
  memory_address_decode_pkg::periph_bus_type periph_o;
  memory_address_decode_pkg::dma_port_type   dma_port_i;

  memory_address_decode #(.NUM_BLOCKS(NB), .REG_BITS(3), .IO_BASE(IOB), .DMA_BASE(DMB))
    u_memory_address_decode (.clk_sys_i, .rst_i, .pc_i, .instr_o, .data_req_i, .status_i,
    .data_rdata_o, .periph_o, .periph_module_o, .periph_reg_o, .periph_rdata_i,
    .dma_port_i, .dma_rd_i, .dma_rdata_o);
  periph_regs_model u_periph_regs_model (.clk_sys_i, .rst_i, .periph_i(periph_o),
    .rdata_o(periph_rdata_i));

  // 250 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // model region: 0 none, 1 main, 2 io, 3 dma; io wins over dma over main
  function automatic int rgn(logic [17:0] w);
    if (w[17:10] == IOB[17:10]) return 2;
    if (w[17:10] == DMB[17:10]) return 3;
    return (w[17:11] < NB) ? 1 : 0;
  endfunction : rgn

  function automatic int key(logic [17:0] w);
    return (rgn(w) << 18) | int'(w);
  endfunction : key

  task automatic chk(logic [17:0] got, logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one data access by word address; request held one clock, result next cycle
  task automatic acc(bit lf, bit lh, bit sf, bit sh, logic [17:0] w, bit al, logic [17:0] d);
    logic [17:0] v;
    v = (rgn(w) != 0 && mem.exists(key(w))) ? mem[key(w)] : 18'h00000;
    if (lh && !lf) v = al ? {9'h000, v[8:0]} : {9'h000, v[17:9]};
    data_req_i = '{{w[16:0], al}, lh, lf, sh, sf, d};
    status_i = (18'($urandom) & ~18'h00080) | {10'h000, w[17], 7'h00};
    @(posedge clk_sys_i);
    #1;
    if (lf || lh) chk(data_rdata_o, v);
    if (rgn(w) != 0 && (sf || sh))
    begin
      if (sf || rgn(w) == 2) mem[key(w)] = d; // io ignores the align bit
      else if (al) mem[key(w)][8:0] = d[8:0];
      else mem[key(w)][17:9] = d[8:0];
    end
  endtask : acc

  // peripheral side of the dma buffer
  task automatic dp(logic [9:0] r, logic [1:0] ln, logic [17:0] d, bit rd);
    int k;
    k = key({DMB[17:10], r});
    data_req_i = '0; // no stale store on the core side
    dma_port_i = '{r, ln, d};
    dma_rd_i = rd;
    @(posedge clk_sys_i);
    #1;
    if (rd) chk(dma_rdata_o, mem[k]);
    if (ln[1]) mem[k][17:9] = d[17:9];
    if (ln[0]) mem[k][8:0] = d[8:0];
  endtask : dp

  task automatic fe(logic [17:0] p);
    pc_i = p;
    data_req_i = '0;
    @(posedge clk_sys_i);
    #1;
    chk(instr_o, (rgn(p) == 1) ? mem[key(p)] : 18'h00000);
  endtask : fe

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // cut a hang short
  initial
  begin
    #20000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial
  begin
    rst_i = 1'b1;
    pc_i = 18'h00000;
    status_i = 18'h00000;
    data_req_i = '0;
    dma_port_i = '0;
    dma_rd_i = 1'b0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(17));
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    foreach (alist[i])
    begin
      acc(0, 0, 1, 0, alist[i], 0, 18'($urandom));
      acc(1, 0, 0, 0, alist[i], 0, 18'h00000);
    end
    for (int i = 0; i < 2; i++)
    begin
      acc(0, 0, 0, 1, alist[1], i[0], 18'($urandom));
      acc(1, 0, 0, 0, alist[1], 0, 18'h00000);
      acc(0, 1, 0, 0, alist[1], i[0], 18'h00000);
    end
    acc(0, 0, 1, 1, alist[2], 1, 18'($urandom));
    acc(1, 1, 0, 0, alist[2], 1, 18'h00000);
    $display("test main memory done");
    foreach (alist[i]) fe(alist[i]);
    fe(DMB);
    fe(18'h04000);
    $display("test fetch port done");
    for (int i = 0; i < 3; i++)
    begin
      acc(0, 0, 1, 0, IOB + 18'(i * 9), 0, 18'($urandom));
      acc(0, 0, 0, 1, IOB + 18'(i * 9), 1, 18'($urandom));
      acc(1, 0, 0, 0, IOB + 18'(i * 9), 0, 18'h00000);
      acc(0, 1, 0, 0, IOB + 18'(i * 9), 1, 18'h00000);
    end
    acc(0, 0, 1, 0, 18'h20000, 0, 18'($urandom));
    acc(1, 0, 0, 0, 18'h20000, 0, 18'h00000);
    acc(1, 0, 0, 0, alist[0], 0, 18'h00000);
    $display("test io and upper memory done");
    acc(0, 0, 1, 0, DMB + 18'h00005, 0, 18'($urandom));
    dp(10'h005, 2'b00, 18'h00000, 1);
    dp(10'h009, 2'b11, 18'($urandom), 0);
    dp(10'h009, 2'b01, 18'($urandom), 0);
    dp(10'h009, 2'b00, 18'h00000, 1);
    acc(1, 0, 0, 0, DMB + 18'h00009, 0, 18'h00000);
    acc(0, 0, 0, 1, DMB + 18'h00009, 0, 18'($urandom));
    acc(0, 1, 0, 0, DMB + 18'h00009, 1, 18'h00000);
    dp(10'h009, 2'b00, 18'h00000, 1);
    $display("test dma buffer done");
    repeat (40)
    begin
      automatic int op = $urandom % 4;
      acc(op == 0, op == 1, op == 2, op == 3, alist[$urandom % 4], 1'($urandom),
          18'($urandom));
    end
    $display("test random access done");
    results();
  end
endmodule : tb
